// >>> rtcta_top.sv
// Real time clock with alarm, calibration and clock output control behind AXI4-Lite
`timescale 1ns/1ps
module rtcta_top
	import rtcta_pkg::*;
(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic XTAL_32K_IN,
	input wire logic MAIN_SUPPLY_OK,
	input wire logic SYS_ON,
	output logic PROC_REF_CLOCK_OUT,
	output logic PERIPH_REF_CLOCK_OUT,
	output logic SECURE_SUPPLY_EN,
	output logic ALARM_WAKE,
	output logic IRQ,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	logic rst_ff1_reg;
	logic rst_ff2_reg;
	logic rst_n;
	logic [RTCTA_NSYNC-1:0] pin_raw;
	logic [RTCTA_NSYNC-1:0] pin_sync;
	logic xtal_s;
	logic main_ok_s;
	logic sys_on_s;
	logic xtal_d_reg;
	logic tick32;
	logic sec_tick;
	logic rtc_disable_reg;
	logic rights_keepalive_mode_reg;
	logic proc_clock_out_enable_reg;
	logic [1:0] cal_enable_mode_reg;
	logic [RTCTA_CAL_W-1:0] cal_word_reg;
	logic cal_active;
	logic [RTCTA_SEC_W-1:0] seconds_reg;
	logic [RTCTA_DAY_W-1:0] day_reg;
	logic [RTCTA_SEC_W-1:0] alarm_seconds_reg;
	logic [RTCTA_DAY_W-1:0] alarm_day_reg;
	logic [2:0] flags_reg;
	logic [2:0] mask_reg;
	logic match;
	logic match_d_reg;
	logic alarm_hit;
	logic aw_held_reg;
	logic w_held_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic wr_do;
	logic [31:0] rd_word;
	logic rd_ok;
	logic [31:0] ctrl_word;
	logic [31:0] wr_old;
	logic [31:0] wr_word;

	// Byte-lane merge for partial writes
	function automatic logic [31:0] rtcta_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (wd & m);
	endfunction

	// Address decode shared by the read path and the write-response path
	function automatic logic rtcta_mapped(input logic [7:0] a);
		return (a == RTCTA_OFS_CTRL) || (a == RTCTA_OFS_FLAGS) || (a == RTCTA_OFS_MASK) ||
			(a == RTCTA_OFS_SECONDS) || (a == RTCTA_OFS_DAY) || (a == RTCTA_OFS_ALARM_SEC) ||
			(a == RTCTA_OFS_ALARM_DAY);
	endfunction

	// Release of the backup power-on reset through two flops
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rst_ff1_reg <= 1'b0;
			rst_ff2_reg <= 1'b0;
		end else begin
			rst_ff1_reg <= 1'b1;
			rst_ff2_reg <= rst_ff1_reg;
		end
	end
	assign rst_n = rst_ff2_reg;

	// Pin inputs all pass the same three-stage filter
	assign pin_raw = {SYS_ON, MAIN_SUPPLY_OK, XTAL_32K_IN};
	generate
		for (genvar i = 0; i < RTCTA_NSYNC; i++) begin : g_sync
			rtcta_sync u_sync (
				.clk(CLK),
				.rst_n(rst_n),
				.din(pin_raw[i]),
				.dout(pin_sync[i])
			);
		end
	endgenerate
	assign xtal_s = pin_sync[0];
	assign main_ok_s = pin_sync[1];
	assign sys_on_s = pin_sync[2];

	// Rising edge of the time base becomes a one-cycle enable
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			xtal_d_reg <= 1'b0;
		end else begin
			xtal_d_reg <= xtal_s;
		end
	end
	assign tick32 = xtal_s & ~xtal_d_reg;

	// Mode 01 drops calibration on coin cell alone; 10 is treated as off
	assign cal_active = (cal_enable_mode_reg == RTCTA_MODE_ALWAYS) ||
		((cal_enable_mode_reg == RTCTA_MODE_MAINS) && main_ok_s);

	rtcta_secdiv u_div (
		.clk(CLK),
		.rst_n(rst_n),
		.tick32(tick32),
		.run(~rtc_disable_reg),
		.cal_en(cal_active),
		.cal_word(cal_word_reg),
		.sec_tick(sec_tick)
	);

	// Write takes place once address and data are both held
	assign wr_do = aw_held_reg & w_held_reg & ~S_AXI_BVALID;

	// Present contents of the addressed register, merged with the enabled byte lanes
	// Flags are write-one-to-clear and take the raw data, so they have no entry here
	always_comb begin
		case (awaddr_reg)
			RTCTA_OFS_CTRL: wr_old = ctrl_word;
			RTCTA_OFS_MASK: wr_old = {29'h0, mask_reg};
			RTCTA_OFS_SECONDS: wr_old = {15'h0, seconds_reg};
			RTCTA_OFS_DAY: wr_old = {17'h0, day_reg};
			RTCTA_OFS_ALARM_SEC: wr_old = {15'h0, alarm_seconds_reg};
			RTCTA_OFS_ALARM_DAY: wr_old = {17'h0, alarm_day_reg};
			default: wr_old = 32'h00000000;
		endcase
		// One merged word serves every register but the flags, so no lane logic is repeated per field
		wr_word = rtcta_merge(wr_old, wdata_reg, wstrb_reg);
	end

	// AXI write channel: address and data accepted in either order
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RTCTA_RESP_OKAY;
		end else begin
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			if (S_AXI_AWVALID && !aw_held_reg && !S_AXI_AWREADY) begin
				S_AXI_AWREADY <= 1'b1;
				aw_held_reg <= 1'b1;
				awaddr_reg <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && !w_held_reg && !S_AXI_WREADY) begin
				S_AXI_WREADY <= 1'b1;
				w_held_reg <= 1'b1;
				wdata_reg <= S_AXI_WDATA;
				wstrb_reg <= S_AXI_WSTRB;
			end
			if (wr_do) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= rtcta_mapped(awaddr_reg) ? RTCTA_RESP_OKAY : RTCTA_RESP_SLVERR;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
			end
		end
	end

	// Control and mask registers; rtc_disable powers up clear so the clock runs
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			rtc_disable_reg <= 1'b0;
			rights_keepalive_mode_reg <= 1'b0;
			proc_clock_out_enable_reg <= 1'b1;
			cal_enable_mode_reg <= RTCTA_MODE_RST;
			cal_word_reg <= '0;
			mask_reg <= RTCTA_MASK_RST;
		end else if (wr_do) begin
			if (awaddr_reg == RTCTA_OFS_CTRL) begin
				rtc_disable_reg <= wr_word[RTCTA_CTRL_DIS];
				rights_keepalive_mode_reg <= wr_word[RTCTA_CTRL_KEEP];
				proc_clock_out_enable_reg <= wr_word[RTCTA_CTRL_PCLKEN];
				cal_enable_mode_reg <= wr_word[RTCTA_CTRL_MODE_LO +: 2];
				cal_word_reg <= wr_word[RTCTA_CTRL_CAL_LO +: RTCTA_CAL_W];
			end
			if (awaddr_reg == RTCTA_OFS_MASK) begin
				mask_reg <= wr_word[2:0];
			end
		end
	end

	// Time and day counters; a software write overrides a tick in the same cycle
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			seconds_reg <= '0;
			day_reg <= '0;
		end else if (wr_do && awaddr_reg == RTCTA_OFS_SECONDS) begin
			seconds_reg <= wr_word[RTCTA_SEC_W-1:0];
		end else if (wr_do && awaddr_reg == RTCTA_OFS_DAY) begin
			day_reg <= wr_word[RTCTA_DAY_W-1:0];
		end else if (sec_tick) begin
			if (seconds_reg >= RTCTA_SEC_LAST) begin
				seconds_reg <= '0;
				day_reg <= day_reg + 15'h0001;
			end else begin
				seconds_reg <= seconds_reg + 17'h00001;
			end
		end
	end

	// Alarm time comes up all ones so a fresh cell never matches early
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			alarm_seconds_reg <= RTCTA_ALARM_SEC_RST;
			alarm_day_reg <= RTCTA_ALARM_DAY_RST;
		end else if (wr_do && awaddr_reg == RTCTA_OFS_ALARM_SEC) begin
			alarm_seconds_reg <= wr_word[RTCTA_SEC_W-1:0];
		end else if (wr_do && awaddr_reg == RTCTA_OFS_ALARM_DAY) begin
			alarm_day_reg <= wr_word[RTCTA_DAY_W-1:0];
		end
	end

	// Match is edge detected so a cleared flag does not reset during the matching second
	assign match = (seconds_reg == alarm_seconds_reg) && (day_reg == alarm_day_reg);
	assign alarm_hit = match & ~match_d_reg;
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			match_d_reg <= 1'b1;
		end else begin
			match_d_reg <= match;
		end
	end

	// Sticky flags, write one to clear; a new event beats a clear in the same cycle
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			flags_reg <= RTCTA_FLAGS_RST;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (wr_do && awaddr_reg == RTCTA_OFS_FLAGS && wstrb_reg[0] && wdata_reg[i]) begin
					flags_reg[i] <= 1'b0;
				end
			end
			if (sec_tick) begin
				flags_reg[RTCTA_F_SEC] <= 1'b1;
			end
			if (alarm_hit) begin
				flags_reg[RTCTA_F_ALARM] <= 1'b1;
			end
		end
	end

	// Interrupt only while the system runs; while off an unmasked alarm is a turn-on event
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			IRQ <= 1'b0;
			ALARM_WAKE <= 1'b0;
		end else begin
			IRQ <= sys_on_s && ((flags_reg & ~mask_reg) != 3'h0);
			ALARM_WAKE <= !sys_on_s && alarm_hit && !mask_reg[RTCTA_F_ALARM];
		end
	end

	// Clock outputs follow the raw time base, never the calibrated divider
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			PROC_REF_CLOCK_OUT <= 1'b0;
			PERIPH_REF_CLOCK_OUT <= 1'b0;
			SECURE_SUPPLY_EN <= 1'b0;
		end else begin
			// Keepalive holds the driver on through every state, including off
			PROC_REF_CLOCK_OUT <= xtal_s & (rights_keepalive_mode_reg |
				(proc_clock_out_enable_reg & sys_on_s));
			PERIPH_REF_CLOCK_OUT <= xtal_s & sys_on_s;
			SECURE_SUPPLY_EN <= 1'b1;
		end
	end

	// Read mux
	assign ctrl_word = {22'h0, cal_word_reg, cal_enable_mode_reg, proc_clock_out_enable_reg,
		rights_keepalive_mode_reg, rtc_disable_reg};
	always_comb begin
		rd_word = 32'h00000000;
		rd_ok = rtcta_mapped(S_AXI_ARADDR);
		case (S_AXI_ARADDR)
			RTCTA_OFS_CTRL: rd_word = ctrl_word;
			RTCTA_OFS_FLAGS: rd_word = {29'h0, flags_reg};
			RTCTA_OFS_MASK: rd_word = {29'h0, mask_reg};
			RTCTA_OFS_SECONDS: rd_word = {15'h0, seconds_reg};
			RTCTA_OFS_DAY: rd_word = {17'h0, day_reg};
			RTCTA_OFS_ALARM_SEC: rd_word = {15'h0, alarm_seconds_reg};
			RTCTA_OFS_ALARM_DAY: rd_word = {17'h0, alarm_day_reg};
			default: rd_word = 32'h00000000;
		endcase
	end

	// AXI read channel, one read outstanding
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= RTCTA_RESP_OKAY;
		end else begin
			S_AXI_ARREADY <= 1'b0;
			if (S_AXI_ARVALID && !S_AXI_RVALID && !S_AXI_ARREADY) begin
				S_AXI_ARREADY <= 1'b1;
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= rd_word;
				S_AXI_RRESP <= rd_ok ? RTCTA_RESP_OKAY : RTCTA_RESP_SLVERR;
			end else if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end
endmodule

// >>> rtcta_pkg.sv
// Constants, register map and reset values for the real time clock block
package rtcta_pkg;
	// Register byte offsets
	localparam logic [7:0] RTCTA_OFS_CTRL = 8'h00;
	localparam logic [7:0] RTCTA_OFS_FLAGS = 8'h04;
	localparam logic [7:0] RTCTA_OFS_MASK = 8'h08;
	localparam logic [7:0] RTCTA_OFS_SECONDS = 8'h0c;
	localparam logic [7:0] RTCTA_OFS_DAY = 8'h10;
	localparam logic [7:0] RTCTA_OFS_ALARM_SEC = 8'h14;
	localparam logic [7:0] RTCTA_OFS_ALARM_DAY = 8'h18;
	// Control field positions
	localparam int RTCTA_CTRL_DIS = 0;
	localparam int RTCTA_CTRL_KEEP = 1;
	localparam int RTCTA_CTRL_PCLKEN = 2;
	localparam int RTCTA_CTRL_MODE_LO = 3;
	localparam int RTCTA_CTRL_CAL_LO = 5;
	// Flag and mask bit positions
	localparam int RTCTA_F_SEC = 0;
	localparam int RTCTA_F_ALARM = 1;
	localparam int RTCTA_F_TRST = 2;
	// Widths and counts
	localparam int RTCTA_SEC_W = 17;
	localparam int RTCTA_DAY_W = 15;
	localparam int RTCTA_CAL_W = 5;
	localparam int RTCTA_DIV_W = 17;
	localparam logic [16:0] RTCTA_SEC_LAST = 17'h1517f;
	localparam logic [16:0] RTCTA_DIV_NOMINAL = 17'h08000;
	// Largest day count and reset values
	localparam logic [14:0] RTCTA_DAY_MAX = 15'h7fff;
	localparam logic [16:0] RTCTA_ALARM_SEC_RST = 17'h1ffff;
	localparam logic [14:0] RTCTA_ALARM_DAY_RST = 15'h7fff;
	localparam logic [2:0] RTCTA_MASK_RST = 3'h7;
	localparam logic [2:0] RTCTA_FLAGS_RST = 3'h4;
	localparam logic [1:0] RTCTA_MODE_RST = 2'h0;
	// Calibration enable modes
	localparam logic [1:0] RTCTA_MODE_OFF = 2'h0;
	localparam logic [1:0] RTCTA_MODE_MAINS = 2'h1;
	localparam logic [1:0] RTCTA_MODE_ALWAYS = 2'h3;
	// AXI responses
	localparam logic [1:0] RTCTA_RESP_OKAY = 2'h0;
	localparam logic [1:0] RTCTA_RESP_SLVERR = 2'h2;
	// Number of synchronised pin inputs
	localparam int RTCTA_NSYNC = 3;
endpackage

// >>> rtcta_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module rtcta_sync
	import rtcta_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic din,
	output logic dout
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	// Shift chain; only s2 reads s1
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// Output holds until the last two stages agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dout <= 1'b0;
		end else if (s2_reg == s3_reg) begin
			dout <= s3_reg;
		end
	end
endmodule

// >>> rtcta_secdiv.sv
// Calibrated divider from the 32 kHz enable to a one-second tick
`timescale 1ns/1ps
module rtcta_secdiv
	import rtcta_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tick32,
	input wire logic run,
	input wire logic cal_en,
	input wire logic [RTCTA_CAL_W-1:0] cal_word,
	output logic sec_tick
);
	logic [RTCTA_DIV_W-1:0] cnt_reg;
	logic [RTCTA_DIV_W-1:0] term;
	logic [RTCTA_DIV_W-1:0] cal_ext;

	// Positive word shortens the second; disabled calibration gives nominal count
	always_comb begin
		cal_ext = cal_en ? {{(RTCTA_DIV_W-RTCTA_CAL_W){cal_word[RTCTA_CAL_W-1]}}, cal_word} : '0;
		term = RTCTA_DIV_NOMINAL - cal_ext;
	end

	// Only this counter sees calibration, the clock outputs never do
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
			sec_tick <= 1'b0;
		end else begin
			sec_tick <= 1'b0;
			if (!run) begin
				cnt_reg <= '0;
			end else if (tick32) begin
				if (cnt_reg >= term - 17'h00001) begin
					cnt_reg <= '0;
					sec_tick <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg + 17'h00001;
				end
			end
		end
	end
endmodule

// >>> rtcta_monitor.sv
// Port-level assertions and covers for the real time clock block
`timescale 1ns/1ps
module rtcta_monitor
	import rtcta_pkg::*;
(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic XTAL_32K_IN,
	input wire logic SYS_ON,
	input wire logic PERIPH_REF_CLOCK_OUT,
	input wire logic SECURE_SUPPLY_EN,
	input wire logic ALARM_WAKE,
	input wire logic IRQ,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic [1:0] S_AXI_RRESP
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RSTN);
	// Supply must be low in reset, so this one ignores the reset gate; two low samples skip power-up
	supply_reset_a: assert property (disable iff (1'b0) !RSTN [*2] |-> !SECURE_SUPPLY_EN)
		else $error("supply on in reset");
	supply_rise_a: assert property ($rose(RSTN) |-> ##[1:6] SECURE_SUPPLY_EN) else $error("supply late");
	supply_hold_a: assert property (SECURE_SUPPLY_EN |=> SECURE_SUPPLY_EN) else $error("supply dropped");
	// Eight cycles cover the pin filter latency
	irq_when_off_a: assert property (!SYS_ON [*8] |=> !IRQ) else $error("irq while off");
	wake_when_on_a: assert property (SYS_ON [*8] |=> !ALARM_WAKE) else $error("wake while on");
	wake_pulse_a: assert property (ALARM_WAKE |=> !ALARM_WAKE) else $error("wake too long");
	periph_follow_a: assert property (SYS_ON [*8] ##1 $rose(XTAL_32K_IN) |-> ##[2:8] PERIPH_REF_CLOCK_OUT)
		else $error("periph clock stuck");
	read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |-> S_AXI_RVALID) else $error("read late");
	aw_pulse_a: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY) else $error("awready held");
	wake_c: cover property (ALARM_WAKE);
	irq_c: cover property ($rose(IRQ));
	slverr_c: cover property (S_AXI_RVALID && S_AXI_RRESP == RTCTA_RESP_SLVERR);
endmodule

// >>> rtcta_proc_model.sv
// Processor-side stand-in that supplies the 32 kHz time base
`timescale 1ns/1ps
module rtcta_proc_model (
	input wire logic clk,
	input wire logic run,
	output logic xtal,
	output int edges
);
	logic ph_reg;
	initial begin
		xtal = 1'b0;
		ph_reg = 1'b0;
		edges = 0;
	end
	// Half period of two clocks keeps the run short; stands low when stopped
	always @(posedge clk) begin
		if (!run) begin
			ph_reg <= 1'b0;
			xtal <= 1'b0;
		end else begin
			ph_reg <= !ph_reg;
			if (ph_reg) begin
				xtal <= !xtal;
				edges <= edges + (xtal ? 0 : 1);
			end
		end
	end
endmodule

// >>> rtc_time_alarm_calibration_tb.sv
// Self-checking bench for the real time clock block
`timescale 1ns/1ps
module rtc_time_alarm_calibration_tb import rtcta_pkg::*;;
	logic clk = 1'b0, rstn = 1'b0, sys_on = 1'b1, run = 1'b0, main_ok = 1'b1;
	logic [3:0] wstrb = 4'hf;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rv;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic proc_o, per_o, sup_en, wake, irq, awready, wready, bvalid, arready, rvalid, xtal;
	logic [1:0] bresp, rresp, rs;
	int n_fail = 0, n_checks = 0, wakes = 0, proc_edges = 0, edges, p0, e0;
	int exp_n = RTCTA_DIV_NOMINAL - 15;
	always #5 clk = !clk;
	rtcta_proc_model rtcta_proc_model_inst (.clk(clk), .run(run), .xtal(xtal), .edges(edges));
	rtcta_top rtcta_top_inst (.CLK(clk), .RSTN(rstn), .XTAL_32K_IN(xtal), .MAIN_SUPPLY_OK(main_ok), .SYS_ON(sys_on),
		.PROC_REF_CLOCK_OUT(proc_o), .PERIPH_REF_CLOCK_OUT(per_o), .SECURE_SUPPLY_EN(sup_en),
		.ALARM_WAKE(wake), .IRQ(irq), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
	// Wake pulses and reference clock edges are counted as they pass
	// The processor side keeps its own record of alarm-caused turn-ons, the key path cannot tell
	always @(posedge clk) begin
		if (wake === 1'b1)
			wakes <= wakes + 1;
		if ($rose(proc_o))
			proc_edges <= proc_edges + 1;
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Address and data are offered together and each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw = 1'b0;
		w = 1'b0;
		do begin
			@(posedge clk);
			if (awready === 1'b1) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready === 1'b1) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end while (!(aw && w));
		do @(posedge clk); while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rv = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	task automatic chk_rst();
		logic [7:0] a [7] = '{RTCTA_OFS_CTRL, RTCTA_OFS_FLAGS, RTCTA_OFS_MASK, RTCTA_OFS_SECONDS,
			RTCTA_OFS_DAY, RTCTA_OFS_ALARM_SEC, RTCTA_OFS_ALARM_DAY};
		logic [31:0] e [7] = '{32'h4, 32'h4, 32'h7, 32'h0, 32'h0, 32'h1ffff, 32'h7fff};
		for (int i = 0; i < 7; i++) begin
			rd(a[i]);
			chk("reset value", rv, e[i]);
		end
	endtask
	task automatic tally_and_finish();
		if (n_fail == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Watchdog sized for one calibrated second plus the register traffic
	initial begin
		#2500000;
		n_fail++;
		tally_and_finish();
	end
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		chk_rst();
		chk("supply", sup_en, 1);
		rd(8'h40);
		chk("unmapped read", rs, RTCTA_RESP_SLVERR);
		wr(8'h40, 32'h1);
		chk("unmapped write", rs, RTCTA_RESP_SLVERR);
		// Day differs, so a seconds-only match must not flag
		wr(RTCTA_OFS_ALARM_SEC, 32'd100);
		wr(RTCTA_OFS_ALARM_DAY, 32'd5);
		wr(RTCTA_OFS_FLAGS, 32'h7);
		wr(RTCTA_OFS_SECONDS, 32'd100);
		wr(RTCTA_OFS_DAY, 32'd4);
		rd(RTCTA_OFS_FLAGS);
		chk("partial match", rv, 0);
		wr(RTCTA_OFS_DAY, 32'd5);
		rd(RTCTA_OFS_FLAGS);
		chk("alarm flag", rv, 2);
		chk("masked irq", irq, 0);
		wr(RTCTA_OFS_FLAGS, 32'h7);
		wr(RTCTA_OFS_MASK, 32'h5);
		wr(RTCTA_OFS_DAY, 32'd4);
		wr(RTCTA_OFS_DAY, 32'd5);
		rd(RTCTA_OFS_FLAGS);
		chk("alarm irq", irq, 1);
		// With the system off the same match turns it on instead
		wr(RTCTA_OFS_FLAGS, 32'h7);
		sys_on <= 1'b0;
		run <= 1'b1;
		repeat (10) @(posedge clk);
		wr(RTCTA_OFS_DAY, 32'd4);
		wr(RTCTA_OFS_DAY, 32'd5);
		repeat (4) @(posedge clk);
		chk("wake pulses", wakes, 1);
		chk("irq off", irq, 0);
		p0 = proc_edges;
		repeat (200) @(posedge clk);
		chk("ref clock off", proc_edges - p0, 0);
		wr(RTCTA_OFS_CTRL, 32'h6);
		p0 = proc_edges;
		repeat (200) @(posedge clk);
		chk("keepalive", proc_edges - p0 > 40, 1);
		sys_on <= 1'b1;
		// Disable clears the divider so the calibrated second starts clean
		wr(RTCTA_OFS_CTRL, 32'h5);
		wr(RTCTA_OFS_SECONDS, RTCTA_SEC_LAST);
		wr(RTCTA_OFS_DAY, RTCTA_DAY_MAX);
		wr(RTCTA_OFS_FLAGS, 32'h7);
		// Mode 11 must keep calibrating with the main supply gone
		main_ok <= 1'b0;
		wr(RTCTA_OFS_CTRL, 32'h1fc);
		e0 = edges;
		do rd(RTCTA_OFS_SECONDS); while (rv[16:0] === RTCTA_SEC_LAST);
		e0 = edges - e0;
		chk("second length", e0 >= exp_n - 3 && e0 <= exp_n + 5, 1);
		chk("seconds wrap", rv, 0);
		rd(RTCTA_OFS_DAY);
		chk("day wrap", rv, 0);
		rd(RTCTA_OFS_FLAGS);
		chk("tick flag", rv, 1);
		main_ok <= 1'b1;
		// A clear without byte lane zero must leave the flags alone
		wstrb <= 4'h2;
		wr(RTCTA_OFS_FLAGS, 32'h7);
		wstrb <= 4'hf;
		rd(RTCTA_OFS_FLAGS);
		chk("strobed clear", rv, 1);
		// Counters hold non-zero values so the reset below has something to clear
		wr(RTCTA_OFS_SECONDS, 32'd7);
		wr(RTCTA_OFS_DAY, 32'd3);
		// A second reset in mid-run must restore every backup register
		@(posedge clk);
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		chk_rst();
		tally_and_finish();
	end
endmodule
bind rtcta_top rtcta_monitor rtcta_monitor_inst (.*);
